// ==== logic/vipc_ctrl.sv ====
// Interrupt acknowledge, priority and vectoring control for the CPU core
`timescale 1ns/1ps
// Behaviour
// [RULE_01] Reset loads all three urgency flag bytes with all ones.
// [RULE_02] Software writes ones to unused urgency bit positions.
// [RULE_03] Software keeps watchdog urgency flag at one in non-maskable mode.
// [RULE_04] Two edge-select bytes, reset to zero, written as whole bytes.
// [RULE_05] Software writes zero to low four bits of edge_select_a.
// [RULE_06] Status word resets to 02 hex.
// [RULE_07] Any vectored acknowledge or break pushes status word, clears enable.
// [RULE_08] Maskable acknowledge copies source urgency into service level flag.
// [RULE_09] Returns and status pop restore status word; push instruction saves it.
// [RULE_10] Non-maskable request ignores enable and priority, beats every other; here a break at the same boundary wins over it.
// [RULE_11] Non-maskable accept pushes status, pc, clears enable and level, vectors.
// [RULE_12] Non-maskable during its service waits for return plus one instruction.
// [RULE_13] Many non-maskable requests during service yield a single acceptance.
// [RULE_14] Maskable needs request, no mask, enable; low waits while level is zero.
// [RULE_15] Latency 7 to 32 clocks high, 8 to 33 clocks low priority.
// [RULE_16] Higher programmable priority first, ties by fixed default order.
// [RULE_17] Maskable accept pushes status then pc, clears enable, uses own vector.
// [RULE_18] Break always taken, pushes status and pc, vectors via 003E.
// [RULE_19] Software ends break handlers with return-from-break only.
// [RULE_20] Enabled nesting accepts equal or higher urgency, refuses lower.
// [RULE_21] Held requests stay pending until acceptable after one instruction.
// [RULE_22] Nothing nests inside non-maskable service; here a break is still taken during it.
// [RULE_23] Fixed default order ranks source 0 highest to 9 lowest.
// [RULE_24] Request flag clears on acknowledge and on reset.
// [RULE_25] Non-maskable watchdog overflow vectors through 0004 hex.
// [RULE_26] Urgency flag zero means high level, one means low level.
// [RULE_27] Pin edge fields pick falling, rising or both; edge sets request.
// [RULE_28] Acceptance is decided only at instruction boundaries.
module vipc_ctrl
  import vipc_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic [2:0] regSel,
  input wire logic regWe,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  input wire logic [NPIN-1:0] extPin,
  input wire logic [NSRC-1:0] periphReq,
  input wire logic [NSRC-1:0] maskFlag,
  input wire logic wdtNmiMode,
  input wire logic wdtOverflow,
  input wire logic instrDone,
  input wire logic instrReserve,
  input wire logic instrBrk,
  input wire logic instrReti,
  input wire logic instrRetb,
  input wire logic instrPopPsw,
  input wire logic instrPushPsw,
  input wire logic instrEi,
  input wire logic instrDi,
  input wire logic [7:0] stackData,
  output logic seqBusy,
  output logic pushPsw,
  output logic pushPc,
  output logic vecFetch,
  output logic loadPc,
  output logic [15:0] vectorAddr,
  output logic [7:0] pswOut,
  output logic [NSRC-1:0] requestFlags,
  output logic nmiInService
);
  logic [7:0] urgencyA;
  logic [7:0] urgencyB;
  logic [7:0] urgencyC;
  logic [7:0] edgeSelA;
  logic [7:0] edgeSelB;
  logic [7:0] program_status_word;
  logic nmiPend;
  logic regSeen;
  logic ackUrg;
  logic [NSRC-1:0] ackOneHot;
  vipc_kind_e ackKind;
  vipc_state_e state;
  vipc_state_e next_state;

  logic [NPIN-1:0] pinEdge;
  logic [NSRC-1:0] urgency;
  logic [NSRC-1:0] eligible;
  logic [NSRC-1:0] hiPick;
  logic [NSRC-1:0] loPick;
  logic [NSRC-1:0] setReq;
  logic [NSRC-1:0] clrReq;
  logic maskOk;
  logic grantHi;
  logic grantLo;
  logic boundaryOk;
  logic brkGo;
  logic nmiGo;
  logic startAny;

  // Lowest index wins among equal urgency
  function automatic logic [NSRC-1:0] lowest_one(input logic [NSRC-1:0] v);
    lowest_one = v & (~v + NSRC'(1));
  endfunction

  function automatic logic [3:0] onehot_index(input logic [NSRC-1:0] v);
    onehot_index = 4'h0;
    for (int i = 0; i < NSRC; i++) begin
      if (v[i]) begin
        onehot_index = 4'(i);
      end
    end
  endfunction

  vipc_edge_detect #(
    .PINS(NPIN)
  ) u_edge (
    .clock(clock),
    .srst(srst),
    .pins(extPin),
    .modes({edgeSelB[EDGE3_LSB +: 2], edgeSelA[EDGE2_LSB +: 2], edgeSelA[EDGE1_LSB +: 2]}),
    .edges(pinEdge) // [RULE_27]
  );

  // Source order: watchdog, pins 1..3, then peripheral sources 4..9 [RULE_23]
  assign urgency = {urgencyC[URG_HI:URG_LO], urgencyB[URG_HI:URG_LO],
                    urgencyA[URG_HI:URG_LO], urgencyA[URG_WDT_BIT]};

  always_ff @(posedge clock) begin
    if (srst) begin
      urgencyA <= URG_RESET; // [RULE_01]
      urgencyB <= URG_RESET; // [RULE_01]
      urgencyC <= URG_RESET; // [RULE_01]
      edgeSelA <= EDGE_RESET; // [RULE_04]
      edgeSelB <= EDGE_RESET; // [RULE_04]
    end else if (regWe) begin
      unique case (regSel)
        SEL_URG_A: urgencyA <= regWdata;
        SEL_URG_B: urgencyB <= regWdata;
        SEL_URG_C: urgencyC <= regWdata;
        SEL_EDGE_A: edgeSelA <= regWdata; // [RULE_04]
        SEL_EDGE_B: edgeSelB <= regWdata; // [RULE_04]
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      regRdata <= 8'h00;
    end else begin
      unique case (regSel)
        SEL_URG_A: regRdata <= urgencyA;
        SEL_URG_B: regRdata <= urgencyB;
        SEL_URG_C: regRdata <= urgencyC;
        SEL_EDGE_A: regRdata <= edgeSelA;
        SEL_EDGE_B: regRdata <= edgeSelB;
        SEL_PSW: regRdata <= program_status_word;
        default: regRdata <= 8'h00;
      endcase
    end
  end

  // Request flags: set wins over the acknowledge clear
  assign setReq = {periphReq[NSRC-1:NPIN+1], pinEdge, wdtOverflow & ~wdtNmiMode}; // [RULE_27]
  assign clrReq = (state == S_PUSH_PSW && ackKind == KIND_MASK) ? ackOneHot : '0;

  always_ff @(posedge clock) begin
    if (srst) begin
      requestFlags <= '0; // [RULE_24]
    end else begin
      requestFlags <= (requestFlags & ~clrReq) | setReq; // [RULE_24]
    end
  end

  // A register write counts as a holding instruction until the boundary
  always_ff @(posedge clock) begin
    if (srst) begin
      regSeen <= 1'b0;
    end else if (instrDone) begin
      regSeen <= 1'b0;
    end else if (regWe) begin
      regSeen <= 1'b1;
    end
  end

  // Boundary after a holding instruction defers acceptance by one [RULE_21]
  assign boundaryOk = instrDone && state == S_IDLE && !instrReserve && !instrReti
                      && !instrRetb && !instrPopPsw && !instrPushPsw && !instrEi
                      && !instrDi && !regSeen && !regWe; // [RULE_28]

  assign eligible = requestFlags & ~maskFlag; // [RULE_14]
  assign hiPick = lowest_one(eligible & ~urgency); // [RULE_16] [RULE_26]
  assign loPick = lowest_one(eligible & urgency); // [RULE_16]
  assign maskOk = program_status_word[PSW_IE] && !nmiInService; // [RULE_14] [RULE_22]
  assign grantHi = maskOk && (|hiPick); // [RULE_20]
  assign grantLo = maskOk && program_status_word[PSW_ISP] && (|loPick) && !grantHi; // [RULE_14] [RULE_20]

  assign brkGo = instrDone && instrBrk && state == S_IDLE; // [RULE_18]
  assign nmiGo = boundaryOk && nmiPend && !nmiInService && !brkGo; // [RULE_10] [RULE_12]
  assign startAny = brkGo || nmiGo || (boundaryOk && (grantHi || grantLo));

  // One pending slot collapses repeated overflows [RULE_13]
  always_ff @(posedge clock) begin
    if (srst) begin
      nmiPend <= 1'b0;
    end else if (wdtOverflow && wdtNmiMode) begin
      nmiPend <= 1'b1;
    end else if (nmiGo) begin
      nmiPend <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      nmiInService <= 1'b0;
    end else if (nmiGo) begin
      nmiInService <= 1'b1;
    end else if (instrDone && instrReti) begin
      nmiInService <= 1'b0; // [RULE_12]
    end
  end

  // Break ahead of the non-maskable one: the executing instruction owns it
  always_ff @(posedge clock) begin
    if (srst) begin
      ackKind <= KIND_MASK;
      ackOneHot <= '0;
      ackUrg <= 1'b1;
      vectorAddr <= 16'h0000;
    end else if (startAny) begin
      if (brkGo) begin
        ackKind <= KIND_BRK;
        ackOneHot <= '0;
        vectorAddr <= VEC_BRK; // [RULE_18]
      end else if (nmiGo) begin
        ackKind <= KIND_NMI;
        ackOneHot <= '0;
        vectorAddr <= VEC_NMI; // [RULE_25]
      end else if (grantHi) begin
        ackKind <= KIND_MASK;
        ackOneHot <= hiPick;
        ackUrg <= 1'b0;
        vectorAddr <= vipc_vector(onehot_index(hiPick)); // [RULE_17]
      end else begin
        ackKind <= KIND_MASK;
        ackOneHot <= loPick;
        ackUrg <= 1'b1;
        vectorAddr <= vipc_vector(onehot_index(loPick)); // [RULE_17]
      end
    end
  end

  // Low urgency spends one extra decision cycle [RULE_15]
  always_comb begin
    next_state = state;
    unique case (state)
      S_IDLE: begin
        if (startAny) begin
          if (!brkGo && !nmiGo && !grantHi) begin
            next_state = S_LOW_WAIT;
          end else begin
            next_state = S_PUSH_PSW;
          end
        end
      end
      S_LOW_WAIT: next_state = S_PUSH_PSW;
      S_PUSH_PSW: next_state = S_PUSH_PC; // [RULE_11] [RULE_17]
      S_PUSH_PC: next_state = S_VEC_LO;
      S_VEC_LO: next_state = S_VEC_HI;
      S_VEC_HI: next_state = S_JUMP;
      S_JUMP: next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Status word; the pushed value is the one before the clear
  always_ff @(posedge clock) begin
    if (srst) begin
      program_status_word <= PSW_RESET; // [RULE_06]
    end else if (regWe && regSel == SEL_PSW) begin
      program_status_word <= regWdata;
    end else if (instrDone && (instrReti || instrRetb || instrPopPsw)) begin
      program_status_word <= stackData; // [RULE_09]
    end else if (state == S_PUSH_PSW) begin
      program_status_word[PSW_IE] <= 1'b0; // [RULE_07]
      if (ackKind == KIND_NMI) begin
        program_status_word[PSW_ISP] <= 1'b0; // [RULE_11]
      end else if (ackKind == KIND_MASK) begin
        program_status_word[PSW_ISP] <= ackUrg; // [RULE_08]
      end
    end else if (instrDone && instrEi) begin
      program_status_word[PSW_IE] <= 1'b1;
    end else if (instrDone && instrDi) begin
      program_status_word[PSW_IE] <= 1'b0;
    end
  end

  assign pswOut = program_status_word;
  assign seqBusy = (state != S_IDLE);
  assign pushPsw = (state == S_PUSH_PSW) || (instrDone && instrPushPsw); // [RULE_07] [RULE_09]
  assign pushPc = (state == S_PUSH_PC); // [RULE_11] [RULE_17] [RULE_18]
  assign vecFetch = (state == S_VEC_LO) || (state == S_VEC_HI);
  assign loadPc = (state == S_JUMP);
endmodule

// ==== inc/vipc_pkg.sv ====
// Constants and types shared by the interrupt priority controller
package vipc_pkg;
  localparam int NSRC = 10;
  localparam int NPIN = 3;

  // Register selects on the core's internal register port
  localparam logic [2:0] SEL_URG_A = 3'h0;
  localparam logic [2:0] SEL_URG_B = 3'h1;
  localparam logic [2:0] SEL_URG_C = 3'h2;
  localparam logic [2:0] SEL_EDGE_A = 3'h3;
  localparam logic [2:0] SEL_EDGE_B = 3'h4;
  localparam logic [2:0] SEL_PSW = 3'h5;

  localparam logic [7:0] URG_RESET = 8'hff;
  localparam logic [7:0] EDGE_RESET = 8'h00;
  localparam logic [7:0] PSW_RESET = 8'h02;

  // Status word bit positions
  localparam int PSW_IE = 7;
  localparam int PSW_ISP = 1;

  // Source bit positions inside the urgency bytes
  localparam int URG_WDT_BIT = 0;
  localparam int URG_LO = 2;
  localparam int URG_HI = 4;

  // Edge field positions: pins 1 and 2 in byte a, pin 3 in byte b
  localparam int EDGE1_LSB = 4;
  localparam int EDGE2_LSB = 6;
  localparam int EDGE3_LSB = 0;

  localparam logic [15:0] VEC_NMI = 16'h0004;
  localparam logic [15:0] VEC_BRK = 16'h003e;

  // Request-to-service latency in CPU clocks
  localparam int LAT_MIN_HIGH = 7;
  localparam int LAT_MIN_LOW = 8;
  localparam int LAT_MAX_HIGH = 32;
  localparam int LAT_MAX_LOW = 33;

  typedef enum logic [1:0] {
    EDGE_FALL = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_NONE = 2'b10,
    EDGE_BOTH = 2'b11
  } vipc_edge_e;

  typedef enum logic [1:0] {
    KIND_MASK = 2'b00,
    KIND_NMI = 2'b01,
    KIND_BRK = 2'b10
  } vipc_kind_e;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_LOW_WAIT = 3'b001,
    S_PUSH_PSW = 3'b010,
    S_PUSH_PC = 3'b011,
    S_VEC_LO = 3'b100,
    S_VEC_HI = 3'b101,
    S_JUMP = 3'b110
  } vipc_state_e;

  // Vector entry of a maskable source by default priority index
  function automatic logic [15:0] vipc_vector(input logic [3:0] idx);
    case (idx)
      4'h0: vipc_vector = 16'h0004;
      4'h1: vipc_vector = 16'h0008;
      4'h2: vipc_vector = 16'h000a;
      4'h3: vipc_vector = 16'h000c;
      4'h4: vipc_vector = 16'h0018;
      4'h5: vipc_vector = 16'h001a;
      4'h6: vipc_vector = 16'h001c;
      4'h7: vipc_vector = 16'h0028;
      4'h8: vipc_vector = 16'h002a;
      default: vipc_vector = 16'h002c;
    endcase
  endfunction
endpackage

// ==== logic/vipc_edge_detect.sv ====
// Valid-edge detector for the external interrupt pins
`timescale 1ns/1ps
module vipc_edge_detect
  import vipc_pkg::*;
#(
  parameter int PINS = NPIN
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [PINS-1:0] pins,
  input wire logic [2*PINS-1:0] modes,
  output logic [PINS-1:0] edges
);
  logic [PINS-1:0] prevPins;
  logic armed;

  // First cycle after reset only captures, so no phantom edge appears
  always_ff @(posedge clock) begin
    if (srst) begin
      prevPins <= '0;
      armed <= 1'b0;
    end else begin
      prevPins <= pins;
      armed <= 1'b1;
    end
  end

  always_comb begin
    edges = '0;
    for (int i = 0; i < PINS; i++) begin
      unique case (vipc_edge_e'(modes[2*i +: 2]))
        EDGE_FALL: edges[i] = armed & prevPins[i] & ~pins[i];
        EDGE_RISE: edges[i] = armed & ~prevPins[i] & pins[i];
        EDGE_BOTH: edges[i] = armed & (prevPins[i] ^ pins[i]);
        EDGE_NONE: edges[i] = 1'b0;
      endcase
    end
  end
endmodule

// ==== verification/vipc_ctrl_props.sv ====
// Port checker for the interrupt acknowledge controller
`timescale 1ns/1ps
module vipc_ctrl_props
  import vipc_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic [2:0] regSel,
  input wire logic regWe,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic instrDone,
  input wire logic instrReserve,
  input wire logic instrBrk,
  input wire logic instrReti,
  input wire logic instrRetb,
  input wire logic instrPopPsw,
  input wire logic instrPushPsw,
  input wire logic instrEi,
  input wire logic instrDi,
  input wire logic seqBusy,
  input wire logic pushPsw,
  input wire logic pushPc,
  input wire logic vecFetch,
  input wire logic loadPc,
  input wire logic [15:0] vectorAddr,
  input wire logic [7:0] pswOut,
  input wire logic nmiInService
);
  logic holding;
  assign holding = instrReserve | instrReti | instrRetb | instrPopPsw | instrPushPsw
    | instrEi | instrDi;
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  property p_rst; $fell(srst) |-> pswOut == PSW_RESET; endproperty
  a_rst: assert property (p_rst) else $error("status word not at reset value");
  property p_order; pushPsw && seqBusy |=> pushPc; endproperty
  a_order: assert property (p_order) else $error("pc push not after status push");
  property p_vec; pushPc |=> vecFetch[*2] ##1 loadPc; endproperty
  a_vec: assert property (p_vec) else $error("vector fetch sequence broken");
  property p_ie; pushPc |-> !pswOut[PSW_IE]; endproperty
  a_ie: assert property (p_ie) else $error("enable flag not cleared on accept");
  property p_nmi_vec;
    loadPc && nmiInService && vectorAddr != VEC_BRK |-> vectorAddr == VEC_NMI
      && !pswOut[PSW_ISP];
  endproperty
  a_nmi_vec: assert property (p_nmi_vec) else $error("bad non-maskable entry");
  property p_nmi_block; instrDone && nmiInService && !instrBrk |=> !seqBusy; endproperty
  a_nmi_block: assert property (p_nmi_block) else $error("accept inside nmi service");
  property p_hold; instrDone && holding && !instrBrk |=> !seqBusy; endproperty
  a_hold: assert property (p_hold) else $error("accept after holding instruction");
  property p_brk;
    instrDone && instrBrk && !seqBusy |=> pushPsw ##1 pushPc ##1 vecFetch[*2]
      ##1 (loadPc && vectorAddr == VEC_BRK);
  endproperty
  a_brk: assert property (p_brk) else $error("break trap sequence wrong");
  property p_busy; $rose(seqBusy) |-> ##[4:5] loadPc ##1 !seqBusy; endproperty
  a_busy: assert property (p_busy) else $error("acknowledge length wrong");
  property p_rd;
    (regWe && regSel == SEL_EDGE_B) ##1 (regSel == SEL_EDGE_B && !regWe)[*2]
      |-> regRdata == $past(regWdata, 2);
  endproperty
  a_rd: assert property (p_rd) else $error("edge select readback wrong");
endmodule

bind vipc_ctrl vipc_ctrl_props u_props (.clock, .srst, .regSel, .regWe, .regWdata,
  .regRdata, .instrDone, .instrReserve, .instrBrk, .instrReti, .instrRetb, .instrPopPsw,
  .instrPushPsw, .instrEi, .instrDi, .seqBusy, .pushPsw, .pushPc, .vecFetch, .loadPc,
  .vectorAddr, .pswOut, .nmiInService);

// ==== verification/vipc_cpu_model.sv ====
// Core stack model keeping saved status words
`timescale 1ns/1ps
module vipc_cpu_model (
  input wire logic clock,
  input wire logic srst,
  input wire logic pushPsw,
  input wire logic [7:0] pswOut,
  input wire logic instrDone,
  input wire logic instrReti,
  input wire logic instrRetb,
  output logic [7:0] stackData
);
  logic [7:0] mem [8];
  logic [2:0] sp;
  // Pc bytes are not kept; only status words matter here
  always_ff @(posedge clock) begin
    if (srst) begin
      sp <= 3'h0;
    end else if (pushPsw) begin
      mem[sp] <= pswOut;
      sp <= sp + 3'h1;
    end else if (instrDone && (instrReti || instrRetb)) begin
      sp <= sp - 3'h1;
    end
  end
  assign stackData = mem[sp - 3'h1];
endmodule

// ==== verification/tb.sv ====
// Self-checking bench for the interrupt acknowledge controller
`timescale 1ns/1ps
module tb
  import vipc_pkg::*;
;
  logic clock, srst, regWe, wdtNmiMode, wdtOverflow, instrDone;
  logic instrBrk, instrReti, instrRetb, instrEi, seqBusy, pushPsw, pushPc, vecFetch;
  logic loadPc, nmiInService;
  logic [2:0] regSel, extPin;
  logic [7:0] regWdata, regRdata, stackData, pswOut;
  logic [NSRC-1:0] periphReq, maskFlag, requestFlags;
  logic [15:0] vectorAddr;
  int nFail, checkCount;

  vipc_ctrl uut (.clock, .srst, .regSel, .regWe, .regWdata, .regRdata, .extPin,
    .periphReq, .maskFlag, .wdtNmiMode, .wdtOverflow, .instrDone, .instrReserve(1'b0),
    .instrBrk, .instrReti, .instrRetb, .instrPopPsw(1'b0), .instrPushPsw(1'b0),
    .instrEi, .instrDi(1'b0), .stackData, .seqBusy, .pushPsw, .pushPc, .vecFetch,
    .loadPc, .vectorAddr, .pswOut, .requestFlags, .nmiInService);
  vipc_cpu_model cpu (.clock, .srst, .pushPsw, .pswOut, .instrDone, .instrReti,
    .instrRetb, .stackData);

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp) begin
      nFail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    @(negedge clock);
    regSel = s;
    regWdata = d;
    regWe = 1'b1;
    @(negedge clock);
    regWe = 1'b0;
  endtask
  task automatic rd(input logic [2:0] s, input logic [7:0] e);
    @(negedge clock);
    regSel = s;
    repeat (2) @(negedge clock);
    chk("register", {8'h00, regRdata}, {8'h00, e});
  endtask
  // Flags: 1 enable, 2 return irq, 4 return break, 8 break
  task automatic bnd(input logic [3:0] f);
    @(negedge clock);
    instrDone = 1'b1;
    {instrBrk, instrRetb, instrReti, instrEi} = f;
    @(negedge clock);
    instrDone = 1'b0;
    {instrBrk, instrRetb, instrReti, instrEi} = 4'h0;
  endtask
  task automatic acc(input logic [15:0] v);
    int i;
    i = 0;
    while (loadPc !== 1'b1 && i < 10) begin
      @(negedge clock);
      i++;
    end
    chk("vector", vectorAddr, v);
    @(negedge clock);
  endtask
  task automatic none();
    repeat (3) @(negedge clock);
    chk("busy", {15'h0, seqBusy}, 16'h0000);
  endtask
  task automatic ovf();
    @(negedge clock);
    wdtOverflow = 1'b1;
    @(negedge clock);
    wdtOverflow = 1'b0;
  endtask

  task automatic t_reset();
    logic [7:0] e [8] = '{8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) begin
      rd(3'(i), e[i]);
    end
    $display("reset values test done");
  endtask
  task automatic t_prio();
    maskFlag = 10'h000;
    wr(SEL_URG_C, 8'heb);
    @(negedge clock);
    periphReq = 10'h090;
    @(negedge clock);
    periphReq = 10'h000;
    bnd(4'h1);
    bnd(4'h0);
    acc(16'h0028);
    chk("status", pswOut, 8'h00);
    chk("requests", requestFlags, 10'h010);
    bnd(4'h1);
    bnd(4'h0);
    none();
    bnd(4'h2);
    none();
    chk("status", pswOut, 8'h82);
    bnd(4'h0);
    acc(16'h0018);
    chk("status", pswOut, 8'h02);
    $display("priority test done");
  endtask
  task automatic t_nmi();
    wdtNmiMode = 1'b1;
    ovf();
    bnd(4'h0);
    acc(VEC_NMI);
    chk("nmi status", {nmiInService, pswOut}, 16'h0100);
    ovf();
    ovf();
    bnd(4'h0);
    none();
    bnd(4'h2);
    none();
    chk("nmi status", {nmiInService, pswOut}, 16'h0002);
    bnd(4'h0);
    acc(VEC_NMI);
    bnd(4'h2);
    bnd(4'h0);
    none();
    $display("non-maskable test done");
  endtask
  task automatic t_brk();
    bnd(4'h1);
    bnd(4'h8);
    acc(VEC_BRK);
    chk("status", pswOut, 8'h02);
    bnd(4'h4);
    chk("status", pswOut, 8'h82);
    $display("break test done");
  endtask
  task automatic t_edge();
    maskFlag = 10'h3ff;
    wr(SEL_EDGE_A, 8'hd0);
    rd(SEL_EDGE_A, 8'hd0);
    // Pin 3 first off, so a nonzero byte proves the write path
    wr(SEL_EDGE_B, 8'h02);
    rd(SEL_EDGE_B, 8'h02);
    extPin = 3'h7;
    repeat (3) @(negedge clock);
    chk("pin requests", requestFlags[3:1], 3'h3);
    extPin = 3'h0;
    repeat (3) @(negedge clock);
    chk("pin requests", requestFlags[3:1], 3'h3);
    wr(SEL_EDGE_B, 8'h00);
    rd(SEL_EDGE_B, 8'h00);
    extPin = 3'h7;
    repeat (3) @(negedge clock);
    chk("pin requests", requestFlags[3:1], 3'h3);
    extPin = 3'h0;
    repeat (3) @(negedge clock);
    chk("pin requests", requestFlags[3:1], 3'h7);
    $display("edge select test done");
  endtask

  task automatic finishTest();
    $display("checks %0d mismatches %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial begin
    repeat (3000) @(posedge clock);
    nFail++;
    finishTest();
  end
  initial begin
    {srst, regWe, wdtNmiMode, wdtOverflow, instrDone} = 5'h10;
    {instrBrk, instrRetb, instrReti, instrEi} = 4'h0;
    {regSel, extPin, regWdata} = 14'h0000;
    periphReq = 10'h000;
    maskFlag = 10'h3ff;
    nFail = 0;
    checkCount = 0;
    repeat (4) @(posedge clock);
    @(negedge clock);
    srst = 1'b0;
    t_reset();
    t_prio();
    t_nmi();
    t_brk();
    t_edge();
    finishTest();
  end
endmodule
